//--- cogc_board_model.sv
// board side: strap resistors on shared pins and pulled-up serial data
`timescale 1ns/1ps
`default_nettype none
module cogc_board_model (
  input  wire logic [cogc_pkg::STRAP_PINS-1:0] strap_val,
  input  wire logic [cogc_pkg::STRAP_PINS-1:0] strap_pin_oe,
  input  wire cogc_pkg::cogc_clk_out_t         clk_out,
  input  wire logic                            host_sda,
  input  wire logic                            smb_data_oe,
  output logic      [cogc_pkg::STRAP_PINS-1:0] strap_pin_in,
  output logic                                 smb_data_in
);
  import cogc_pkg::*;
  logic [STRAP_PINS-1:0] tone_lvl;
  assign tone_lvl = {clk_out.pci_clocks[0], clk_out.free_pci_clock,
                     clk_out.selectable_rate_clock, clk_out.usb48_clock,
                     clk_out.reference_clock_outputs[1:0]};
  // a released pin settles to its resistor, never to the last clock level
  assign strap_pin_in = (strap_pin_oe & tone_lvl) | (~strap_pin_oe & strap_val);
  assign smb_data_in  = host_sda & ~smb_data_oe;
endmodule : cogc_board_model
`default_nettype wire

//--- cogc_clock_gate_ctrl.sv
// clock output gating, straps, watchdog and serial configuration
//
// Contract
// [RULE_01] ref stop gates refs, 48 and 24/48
// [RULE_02] pci stop gates pci 0..8 and early
// [RULE_03] free-running pci clock ignores pci stop
// [RULE_04] agp_group_halt_n gates all three agp clocks
// [RULE_05] cpu stop gates chipset pair only
// [RULE_06] five straps choose operating frequency
// [RULE_07] pci0 strap picks 24 or 48 MHz
// [RULE_08] watchdog expiry falls back to chosen frequency
// [RULE_09] open-drain reset after expiry or change
// [RULE_10] serial byte and block read/write accepted
// [RULE_11] vendor and revision codes readable
// [RULE_12] power-down input enters power-down mode
// [RULE_13] command bit7 mode, bits6:0 offset
// [RULE_14] halt and power-down inputs active low
// [RULE_15] straps sampled during reset, then held
`timescale 1ns/1ps
`default_nettype none
module cogc_clock_gate_ctrl #(
  parameter logic [6:0]  SMB_ADDR       = 7'h50,
  parameter logic [7:0]  VENDOR_ID      = 8'hA5, // arbitrary value
  parameter logic [7:0]  REVISION_ID    = 8'h01, // arbitrary value
  parameter int unsigned WD_TIMEOUT_CYC = cogc_pkg::WD_TIMEOUT_CYC_DEF
) (
  input  wire logic                                clk_sys,
  input  wire logic                                sys_rst,
  input  wire cogc_pkg::cogc_tone_t                tones,
  input  wire cogc_pkg::cogc_halt_t                halt_pins,
  input  wire logic [cogc_pkg::STRAP_PINS-1:0]     strap_pin_in,
  output logic      [cogc_pkg::STRAP_PINS-1:0]     strap_pin_oe,
  output cogc_pkg::cogc_clk_out_t                  clk_out,
  output logic      [4:0]                          freq_select,
  output logic                                     usb_rate_select,
  output logic                                     sys_reset_n_o,
  output logic                                     sys_reset_oe,
  input  wire logic                                smb_clk_in,
  input  wire logic                                smb_data_in,
  output logic                                     smb_data_o,
  output logic                                     smb_data_oe
);
  import cogc_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ADDR  = 5'b00010,
    S_WRITE = 5'b00100,
    S_READ  = 5'b01000,
    S_SKIP  = 5'b10000
  } cogc_smb_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  cogc_halt_t                  halt_s;
  logic [1:0]                  smb_s;
  logic [STRAP_PINS-1:0]       strap_s;

  cogc_sync3 #(.W(5), .RST_VAL(5'h1F)) u_sync_halt ( // RULE_14
    .clk_sys (clk_sys),
    .rst     (sys_rst),
    .din     (halt_pins),
    .dout    (halt_s)
  );

  cogc_sync3 #(.W(2), .RST_VAL(2'h3)) u_sync_smb (
    .clk_sys (clk_sys),
    .rst     (sys_rst),
    .din     ({smb_clk_in, smb_data_in}),
    .dout    (smb_s)
  );

  // no reset here so straps settle while sys_rst is still high
  cogc_sync3 #(.W(STRAP_PINS), .RST_VAL(6'h3F)) u_sync_strap (
    .clk_sys (clk_sys),
    .rst     (1'b0),
    .din     (strap_pin_in),
    .dout    (strap_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // straps: captured while reset is high, pins turn to outputs after
  logic [STRAP_PINS-1:0] strap_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_r <= strap_s; // RULE_15
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_pin_oe <= '0;
    end else begin
      strap_pin_oe <= '1; // RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output gating
  logic pd_ok;
  logic ref_en;
  logic pci_en;
  logic agp_en;
  logic cpu_en;
  logic sel_tone;

  assign pd_ok  = halt_s.power_down_n; // RULE_12
  assign ref_en = pd_ok & halt_s.ref_group_halt_n;
  assign pci_en = pd_ok & halt_s.pci_group_halt_n;
  assign agp_en = pd_ok & halt_s.agp_group_halt_n;
  assign cpu_en = pd_ok & halt_s.cpu_halt_n;
  assign sel_tone = strap_r[STRAP_SEL] ? tones.rate48_tone
                                       : tones.rate24_tone; // RULE_07

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clk_out <= '0;
    end else begin
      clk_out.reference_clock_outputs <= {3{tones.ref_tone & ref_en}}; // RULE_01
      clk_out.usb48_clock             <= tones.usb48_tone & ref_en; // RULE_01
      clk_out.selectable_rate_clock   <= sel_tone & ref_en; // RULE_01
      clk_out.pci_clocks      <= {9{tones.pci_tone & pci_en}}; // RULE_02
      clk_out.early_pci_clock <= tones.pci_tone & pci_en; // RULE_02
      clk_out.free_pci_clock  <= tones.pci_tone & pd_ok; // RULE_03
      clk_out.graphics_port_clocks <= {3{tones.agp_tone & agp_en}}; // RULE_04
      clk_out.chipset_cpu_clock_true <= tones.cpu_tone & cpu_en; // RULE_05
      clk_out.chipset_cpu_clock_comp <= ~tones.cpu_tone & cpu_en; // RULE_05
      // open-drain pair: enable pulls low, only power-down parks it high
      clk_out.processor_clock_true_oe <= ~tones.cpu_tone & pd_ok; // RULE_05
      clk_out.processor_clock_comp_oe <= tones.cpu_tone & pd_ok; // RULE_05
    end
  end

  assign usb_rate_select = strap_r[STRAP_SEL]; // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // serial slave
  cogc_smb_state_t state_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [1:0] byte_no_r;
  logic       blk_r;
  logic       first_rd_r;
  logic [6:0] ptr_r;
  logic       wr_stb_r;
  logic [6:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_s;
  logic       sda_s;
  logic [7:0] freq_sw_r;
  logic [7:0] ctrl_r;
  logic       wd_fired_r;

  assign scl_s    = smb_s[1];
  assign sda_s    = smb_s[0];
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign smb_data_o = 1'b0;

  always_comb begin
    if (ptr_r == CFG_FREQ) begin
      rd_data = freq_sw_r;
    end else if (ptr_r == CFG_CTRL) begin
      rd_data = ctrl_r;
    end else if (ptr_r == CFG_STAT) begin
      rd_data = {6'h00, strap_r[STRAP_SEL], wd_fired_r};
    end else if (ptr_r == CFG_STRAP) begin
      rd_data = {3'h0, strap_r[4:0]};
    end else if (ptr_r == CFG_VID) begin
      rd_data = VENDOR_ID; // RULE_11
    end else if (ptr_r == CFG_RID) begin
      rd_data = REVISION_ID; // RULE_11
    end else begin
      rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      byte_no_r <= 2'h0;
      blk_r <= 1'b0;
      first_rd_r <= 1'b0;
      ptr_r <= 7'h00;
      wr_stb_r <= 1'b0;
      wr_idx_r <= 7'h00;
      wr_data_r <= 8'h00;
      smb_data_oe <= 1'b0;
    end else begin
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
      wr_stb_r <= 1'b0;
      if (start_ev) begin
        state_r <= S_ADDR;
        // first scl fall after a start is no bit; it wraps the count to 0
        bit_cnt_r <= 4'hF;
        smb_data_oe <= 1'b0;
      end else if (stop_ev) begin
        state_r <= S_IDLE;
        smb_data_oe <= 1'b0;
      end else if (state_r == S_IDLE || state_r == S_SKIP) begin
        smb_data_oe <= 1'b0;
      end else if (scl_rise) begin
        if (bit_cnt_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda_s};
        end else if (state_r == S_READ && sda_s) begin
          state_r <= S_SKIP; // master nack ends the read
        end
      end else if (scl_fall) begin
        if (bit_cnt_r == 4'h7) begin
          bit_cnt_r <= 4'h8;
          case (state_r)
            S_ADDR: begin
              if (shift_r[7:1] == SMB_ADDR) begin
                smb_data_oe <= 1'b1;
                byte_no_r <= 2'h0;
                first_rd_r <= 1'b1;
                state_r <= shift_r[0] ? S_READ : S_WRITE;
              end else begin
                state_r <= S_SKIP;
              end
            end
            S_WRITE: begin
              smb_data_oe <= 1'b1; // RULE_10
              if (byte_no_r != 2'h3) begin
                byte_no_r <= byte_no_r + 2'h1;
              end
              if (byte_no_r == 2'h0) begin
                blk_r <= ~shift_r[CMD_BYTE_MODE_BIT]; // RULE_13
                ptr_r <= shift_r[CMD_BYTE_MODE_BIT] ? shift_r[6:0]
                                                    : 7'h00; // RULE_13
              end else if (!(byte_no_r == 2'h1 && blk_r)) begin
                wr_stb_r  <= 1'b1; // RULE_10
                wr_idx_r  <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r <= ptr_r + 7'h01;
              end
            end
            default: begin
              smb_data_oe <= 1'b0;
            end
          endcase
        end else if (bit_cnt_r == 4'h8) begin
          bit_cnt_r <= 4'h0;
          smb_data_oe <= 1'b0;
          if (state_r == S_READ) begin
            if (blk_r && first_rd_r) begin
              tx_r <= CFG_COUNT; // RULE_10
              smb_data_oe <= ~CFG_COUNT[7];
            end else begin
              tx_r <= rd_data;
              smb_data_oe <= ~rd_data[7];
              ptr_r <= ptr_r + 7'h01;
            end
            first_rd_r <= 1'b0;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (state_r == S_READ) begin
            smb_data_oe <= ~tx_r[6];
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration bytes and watchdog
  logic        freq_chg;
  logic        wd_expire;
  logic [31:0] wd_cnt_r;
  logic [4:0]  rst_cnt_r;

  assign freq_chg  = wr_stb_r && wr_idx_r == CFG_FREQ &&
                     wr_data_r != freq_sw_r;
  assign wd_expire = ctrl_r[CTRL_WD_EN] && !wd_fired_r &&
                     wd_cnt_r == WD_TIMEOUT_CYC - 1;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      freq_sw_r <= FREQ_RST;
      ctrl_r    <= CTRL_RST;
    end else if (wr_stb_r) begin
      if (wr_idx_r == CFG_FREQ) begin
        freq_sw_r <= wr_data_r;
      end else if (wr_idx_r == CFG_CTRL) begin
        ctrl_r <= wr_data_r;
      end
    end
  end

  // any control write restarts the count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_r <= 32'h0;
    end else if ((wr_stb_r && wr_idx_r == CFG_CTRL) ||
                 !ctrl_r[CTRL_WD_EN] || wd_fired_r) begin
      wd_cnt_r <= 32'h0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 32'h1;
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wd_fired_r <= 1'b0;
    end else if (wd_expire) begin
      wd_fired_r <= 1'b1; // RULE_08
    end else if (wr_stb_r && wr_idx_r == CFG_STAT &&
                 wr_data_r[STAT_WD_FIRED]) begin
      wd_fired_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      freq_select <= 5'h00;
    end else if (wd_fired_r) begin
      freq_select <= ctrl_r[CTRL_WD_USE_SW] ? freq_sw_r[4:0]
                                            : strap_r[4:0]; // RULE_08
    end else begin
      freq_select <= ctrl_r[CTRL_USE_SW] ? freq_sw_r[4:0]
                                         : strap_r[4:0]; // RULE_06
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_r <= 5'h00;
    end else if ((wd_expire && ctrl_r[CTRL_RST_ON_WD]) ||
                 (freq_chg && ctrl_r[CTRL_RST_ON_FREQ])) begin
      rst_cnt_r <= 5'(RST_PULSE_CYC); // RULE_09
    end else if (rst_cnt_r != 5'h00) begin
      rst_cnt_r <= rst_cnt_r - 5'h01;
    end
  end

  assign sys_reset_oe  = rst_cnt_r != 5'h00; // RULE_09
  assign sys_reset_n_o = 1'b0;

endmodule : cogc_clock_gate_ctrl
`default_nettype wire

//--- cogc_clock_gate_ctrl_tb.sv
// self-checking bench for the clock output gating control
`timescale 1ns/1ps
`default_nettype none
module cogc_clock_gate_ctrl_tb;
  import cogc_pkg::*;
  logic                  clk_sys   = 1'b0;
  logic                  sys_rst   = 1'b0;
  cogc_tone_t            tones     = '0;
  cogc_halt_t            halt_pins = 5'h1F;
  logic                  scl       = 1'b1;
  logic                  host_sda  = 1'b1;
  logic                  oe_d      = 1'b0;
  logic [STRAP_PINS-1:0] strap_val, strap_pin_in, strap_pin_oe;
  cogc_clk_out_t         clk_out;
  logic [4:0]            freq_select, sw_f;
  logic                  usb_rate_select, sys_reset_n_o, sys_reset_oe;
  logic                  smb_data_in, smb_data_o, smb_data_oe;
  logic [2:0]            nak;
  logic [7:0]            rx;
  localparam logic [7:0] VID_TB    = 8'h3C; // arbitrary value
  int                    bad_count, n_tests, rise_n, r0;
  cogc_clock_gate_ctrl #(.WD_TIMEOUT_CYC(50), .VENDOR_ID(VID_TB)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tones(tones),
    .halt_pins(halt_pins), .strap_pin_in(strap_pin_in),
    .strap_pin_oe(strap_pin_oe), .clk_out(clk_out),
    .freq_select(freq_select), .usb_rate_select(usb_rate_select),
    .sys_reset_n_o(sys_reset_n_o), .sys_reset_oe(sys_reset_oe),
    .smb_clk_in(scl), .smb_data_in(smb_data_in),
    .smb_data_o(smb_data_o), .smb_data_oe(smb_data_oe));
  cogc_board_model u_board (
    .strap_val(strap_val), .strap_pin_oe(strap_pin_oe), .clk_out(clk_out),
    .host_sda(host_sda), .smb_data_oe(smb_data_oe),
    .strap_pin_in(strap_pin_in), .smb_data_in(smb_data_in));
  ////////////////////////////////////////////////////////////////////////////
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  always @(negedge clk_sys) tones <= cogc_tone_t'(7'($urandom()));
  always @(posedge clk_sys) begin
    if (sys_reset_oe && !oe_d) rise_n++;
    oe_d <= sys_reset_oe;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // data moves well inside the low phase so no false start is seen
  task automatic sbit(input logic b, output logic r);
    repeat (4) @(negedge clk_sys);
    host_sda = b;
    repeat (8) @(negedge clk_sys);
    scl = 1'b1;
    repeat (5) @(negedge clk_sys);
    r = smb_data_in;
    repeat (5) @(negedge clk_sys);
    scl = 1'b0;
  endtask : sbit
  task automatic sbyte(input logic [7:0] d, output logic n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      sbit(d[i], r);
      rx = {rx[6:0], r};
    end
    sbit(1'b1, n);
  endtask : sbyte
  task automatic sstart;
    repeat (4) @(negedge clk_sys);
    host_sda = 1'b1;
    repeat (8) @(negedge clk_sys);
    scl = 1'b1;
    repeat (10) @(negedge clk_sys);
    host_sda = 1'b0;
    repeat (10) @(negedge clk_sys);
    scl = 1'b0;
  endtask : sstart
  task automatic sstop;
    repeat (4) @(negedge clk_sys);
    host_sda = 1'b0;
    repeat (8) @(negedge clk_sys);
    scl = 1'b1;
    repeat (10) @(negedge clk_sys);
    host_sda = 1'b1;
  endtask : sstop
  task automatic wr(input logic [7:0] adr, cmd, d, output logic [2:0] n);
    sstart();
    sbyte(adr, n[2]);
    sbyte(cmd, n[1]);
    sbyte(d, n[0]);
    sstop();
  endtask : wr
  // read through a repeated start, master nack; data byte lands in rx
  task automatic rd(input logic [7:0] cmd, output logic [2:0] n);
    logic nk;
    sstart();
    sbyte(8'hA0, n[2]);
    sbyte(cmd, n[1]);
    sstart();
    sbyte(8'hA1, n[0]);
    sbyte(8'hFF, nk);
    sstop();
  endtask : rd
  function automatic logic [15:0] grp(input int i);
    case (i)
      0: grp = 16'({clk_out.reference_clock_outputs, clk_out.usb48_clock,
                    clk_out.selectable_rate_clock});
      1: grp = 16'({clk_out.pci_clocks, clk_out.early_pci_clock});
      2: grp = 16'(clk_out.graphics_port_clocks);
      3: grp = 16'({clk_out.chipset_cpu_clock_true,
                    clk_out.chipset_cpu_clock_comp});
      default: grp = 16'({clk_out.free_pci_clock,
                          clk_out.reference_clock_outputs});
    endcase
  endfunction : grp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7372));
    strap_val = 6'($urandom());
    sw_f = strap_val[4:0] ^ 5'($urandom_range(31, 1));
    // a real rising edge, so the async resets fire before the first clock
    #1 sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(16'(freq_select), 16'(strap_val[4:0]));
    chk(16'(usb_rate_select), 16'(strap_val[STRAP_SEL]));
    for (int i = 0; i < 5; i++) begin
      halt_pins = 5'h1F ^ (5'h10 >> i);
      repeat (6) @(negedge clk_sys);
      repeat (8) begin
        @(negedge clk_sys);
        chk(grp(i), 16'h0000);
        chk(16'(clk_out.free_pci_clock),
            (i == 4) ? 16'h0000 : 16'(tones.pci_tone));
        chk(16'({clk_out.processor_clock_true_oe,
                 clk_out.processor_clock_comp_oe}),
            (i == 4) ? 16'h0000
                     : 16'({~tones.cpu_tone, tones.cpu_tone}));
      end
      halt_pins = 5'h1F;
    end
    repeat (8) @(negedge clk_sys);
    repeat (8) begin
      @(negedge clk_sys);
      chk(16'({clk_out.pci_clocks[0], clk_out.graphics_port_clocks[0],
               clk_out.reference_clock_outputs[2]}),
          16'({tones.pci_tone, tones.agp_tone, tones.ref_tone}));
    end
    wr(8'hB0, 8'h80, 8'h00, nak);
    chk(16'(nak), 16'h0007);
    wr(8'hA0, {1'b1, CFG_FREQ}, 8'(sw_f), nak);
    chk(16'(nak), 16'h0000);
    chk(16'(freq_select), 16'(strap_val[4:0]));
    r0 = rise_n;
    // watchdog on, falls back to the written value, resets the system
    wr(8'hA0, {1'b1, CFG_CTRL}, 8'h07, nak);
    repeat (100) @(negedge clk_sys);
    chk(16'(freq_select), 16'(sw_f));
    chk(16'(rise_n > r0), 16'h0001);
    wr(8'hA0, {1'b1, CFG_CTRL}, 8'h18, nak);
    // fallback is sticky until the fired flag is cleared
    wr(8'hA0, {1'b1, CFG_STAT}, 8'h01, nak);
    repeat (40) @(negedge clk_sys);
    chk(16'(freq_select), 16'(sw_f));
    r0 = rise_n;
    wr(8'hA0, {1'b1, CFG_FREQ}, 8'(sw_f ^ 5'h1F), nak);
    repeat (40) @(negedge clk_sys);
    chk(16'(nak), 16'h0000);
    chk(16'(freq_select), 16'(sw_f ^ 5'h1F));
    chk(16'(rise_n - r0), 16'h0001);
    rd({1'b1, CFG_VID}, nak);
    chk(16'({nak, rx}), 16'({3'h0, VID_TB}));
    rd(8'h00, nak);
    chk(16'({nak, rx}), 16'({3'h0, CFG_COUNT}));
    rd({1'b1, CFG_FREQ}, nak);
    chk(16'(rx), 16'(sw_f ^ 5'h1F));
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
endmodule : cogc_clock_gate_ctrl_tb
`default_nettype wire

//--- cogc_gate_asserts.sv
// concurrent checks on the clock output gating control ports
`timescale 1ns/1ps
`default_nettype none
module cogc_gate_chk (
  input wire logic                            clk_sys,
  input wire logic                            sys_rst,
  input wire cogc_pkg::cogc_tone_t            tones,
  input wire cogc_pkg::cogc_halt_t            halt_pins,
  input wire logic [cogc_pkg::STRAP_PINS-1:0] strap_pin_in,
  input wire logic [cogc_pkg::STRAP_PINS-1:0] strap_pin_oe,
  input wire cogc_pkg::cogc_clk_out_t         clk_out,
  input wire logic                            usb_rate_select,
  input wire logic                            sys_reset_n_o,
  input wire logic                            sys_reset_oe
);
  import cogc_pkg::*;
  logic [STRAP_PINS-1:0] strap_r;
  logic [7:0]            pulse_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // pins only show straps while reset keeps the outputs off
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_r <= strap_pin_in;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_r <= 8'h00;
    end else if (sys_reset_oe) begin
      pulse_r <= pulse_r + 8'h01;
    end else begin
      pulse_r <= 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // six samples cover the synchroniser and the output register
  a_ref_group_off: assert property (
    !halt_pins.ref_group_halt_n [*6] |=> clk_out.reference_clock_outputs
    == 3'h0 && !clk_out.usb48_clock && !clk_out.selectable_rate_clock)
    else $error("ref group running while halted");
  a_pci_group_off: assert property (
    !halt_pins.pci_group_halt_n [*6] |=>
    clk_out.pci_clocks == 9'h000 && !clk_out.early_pci_clock)
    else $error("pci group running while halted");
  a_free_pci_runs: assert property (
    halt_pins.power_down_n [*6] |=>
    clk_out.free_pci_clock == $past(tones.pci_tone))
    else $error("free pci clock not following its tone");
  a_agp_group_off: assert property (
    !halt_pins.agp_group_halt_n [*6] |=> clk_out.graphics_port_clocks == 3'h0)
    else $error("agp group running while halted");
  a_cpu_pair_off: assert property (
    !halt_pins.cpu_halt_n [*6] |=> !clk_out.chipset_cpu_clock_true
    && !clk_out.chipset_cpu_clock_comp)
    else $error("chipset cpu pair running while halted");
  a_power_down_off: assert property (
    !halt_pins.power_down_n [*6] |=> !clk_out.free_pci_clock
    && clk_out.reference_clock_outputs == 3'h0)
    else $error("outputs running in power down");
  a_rate_strap_held: assert property (
    !$past(sys_rst) |-> usb_rate_select == strap_r[STRAP_SEL])
    else $error("rate select differs from captured strap");
  a_pins_driven_after: assert property (
    !$past(sys_rst) |-> strap_pin_oe == 6'h3F)
    else $error("shared pins not driven after reset");
  a_reset_pulse_len: assert property (
    $fell(sys_reset_oe) |-> pulse_r == RST_PULSE_CYC)
    else $error("system reset pulse has wrong length");
  a_reset_pulls_low: assert property (
    sys_reset_oe |-> !sys_reset_n_o)
    else $error("system reset enabled without low level");
endmodule : cogc_gate_chk
bind cogc_clock_gate_ctrl cogc_gate_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .tones(tones),
  .halt_pins(halt_pins), .strap_pin_in(strap_pin_in),
  .strap_pin_oe(strap_pin_oe), .clk_out(clk_out),
  .usb_rate_select(usb_rate_select), .sys_reset_n_o(sys_reset_n_o),
  .sys_reset_oe(sys_reset_oe)
);
`default_nettype wire

//--- cogc_pkg.sv
// shared constants and carrier types for the clock output gating control
package cogc_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned RST_PULSE_NS    = 1000;
  localparam int unsigned RST_PULSE_CYC   =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_TIMEOUT_MS   = 1000;
  localparam int unsigned WD_TIMEOUT_CYC_DEF =
    (WD_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

  // serial command code layout
  localparam int unsigned CMD_BYTE_MODE_BIT = 7;

  // configuration byte indexes
  localparam logic [6:0] CFG_FREQ  = 7'h00;
  localparam logic [6:0] CFG_CTRL  = 7'h01;
  localparam logic [6:0] CFG_STAT  = 7'h02;
  localparam logic [6:0] CFG_STRAP = 7'h03;
  localparam logic [6:0] CFG_VID   = 7'h04;
  localparam logic [6:0] CFG_RID   = 7'h05;
  localparam logic [7:0] CFG_COUNT = 8'h06;

  // control byte fields
  localparam int unsigned CTRL_WD_EN       = 0;
  localparam int unsigned CTRL_WD_USE_SW   = 1;
  localparam int unsigned CTRL_RST_ON_WD   = 2;
  localparam int unsigned CTRL_RST_ON_FREQ = 3;
  localparam int unsigned CTRL_USE_SW      = 4;

  // status byte fields
  localparam int unsigned STAT_WD_FIRED = 0;
  localparam int unsigned STAT_USB24    = 1;

  // reset values
  localparam logic [7:0] FREQ_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // strap pin order on the shared pin vectors
  localparam int unsigned STRAP_PINS = 6;
  localparam int unsigned STRAP_SEL  = 5;

  typedef struct packed {
    logic ref_tone;
    logic usb48_tone;
    logic rate48_tone;
    logic rate24_tone;
    logic pci_tone;
    logic agp_tone;
    logic cpu_tone;
  } cogc_tone_t;

  typedef struct packed {
    logic [2:0] reference_clock_outputs;
    logic       usb48_clock;
    logic       selectable_rate_clock;
    logic       free_pci_clock;
    logic [8:0] pci_clocks;
    logic       early_pci_clock;
    logic [2:0] graphics_port_clocks;
    logic       chipset_cpu_clock_true;
    logic       chipset_cpu_clock_comp;
    logic       processor_clock_true_oe;
    logic       processor_clock_comp_oe;
  } cogc_clk_out_t;

  typedef struct packed {
    logic ref_group_halt_n;
    logic pci_group_halt_n;
    logic agp_group_halt_n;
    logic cpu_halt_n;
    logic power_down_n;
  } cogc_halt_t;

endpackage : cogc_pkg

//--- cogc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cogc_sync3 #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [W-1:0]  din,
  output logic      [W-1:0]  dout
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      dout  <= RST_VAL;
    end else begin
      ff1_r <= din;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      // a bit only changes once two stages agree
      for (int i = 0; i < int'(W); i++) begin
        if (ff2_r[i] == ff3_r[i]) begin
          dout[i] <= ff3_r[i];
        end
      end
    end
  end
endmodule : cogc_sync3
`default_nettype wire
